// *** verilog/mmd_top.sv ***
/*
 * Memory map address decoder: program and data bus region selects,
 * block zero/one aliasing and GPIO reset direction control.
 * Assumes the CPU core drives addresses synchronous to sys_clk and
 * consumes the registered selects one cycle after the address.
 */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - With boot ROM enabled, program addresses 0000-00FF select boot ROM.
// - Boot ROM disabled: program words 0040h-0043h hold security passwords, never ordinary code.
// - Select bit set: program FE00h-FEFFh and FF00h-FFFFh alias block zero.
// - Select bit clear: data 0100h-01FFh and 0200h-02FFh alias block zero.
// - Data 0300h-03FFh and 0400h-04FFh always alias block one.
// - After reset every GPIO is an input with its driver off.
module mmd_top
    import mmd_pkg::*;
#(
    parameter int GPIO_N = mmd_pkg::MMD_GPIO_N
) (
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          srst,
    // Configuration
    input  wire logic                          boot_rom_en,
    input  wire logic                          block_zero_space_select,
    // Program bus
    input  wire logic [mmd_pkg::MMD_AW-1:0]    prog_addr,
    input  wire logic                          prog_req,
    // Data bus
    input  wire logic [mmd_pkg::MMD_AW-1:0]    data_addr,
    input  wire logic                          data_req,
    // Program selects
    output logic                               sel_boot_rom,
    output logic                               sel_pwd,
    output logic                               sel_flash,
    output mmd_pkg::mmd_sel_t                  prog_b0,
    // Data selects
    output mmd_pkg::mmd_sel_t                  data_b0,
    output mmd_pkg::mmd_sel_t                  data_b1,
    // GPIO direction control from software
    input  wire logic                          gpio_dir_we,
    input  wire logic [GPIO_N-1:0]             gpio_dir_wdata,
    input  wire logic [GPIO_N-1:0]             gpio_out_wdata,
    // GPIO pins
    input  wire logic [GPIO_N-1:0]             gpio_in,
    output logic      [GPIO_N-1:0]             gpio_out,
    output logic      [GPIO_N-1:0]             gpio_oe,
    output logic      [GPIO_N-1:0]             gpio_rd
);
    import mmd_pkg::*;

    // Elaboration check; the direction latch serves at most 64 pins
    if (GPIO_N < 1 || GPIO_N > 64) begin : g_bad_gpio_n
        $error("GPIO_N must lie in 1..64");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Window comparators
    logic p_boot_w, p_pwd_w, p_b0_w, d_b0_w, d_b1_w;

    mmd_range #(.AW(MMD_AW), .LO(MMD_BOOT_LO), .HI(MMD_BOOT_HI)) u_pboot (
        .addr (prog_addr),
        .hit  (p_boot_w)
    );
    mmd_range #(.AW(MMD_AW), .LO(MMD_PWD_LO), .HI(MMD_PWD_HI)) u_ppwd (
        .addr (prog_addr),
        .hit  (p_pwd_w)
    );
    mmd_range #(.AW(MMD_AW), .LO(MMD_PB0_LO), .HI(MMD_PB0_HI)) u_pb0 (
        .addr (prog_addr),
        .hit  (p_b0_w)
    );
    mmd_range #(.AW(MMD_AW), .LO(MMD_DB0_LO), .HI(MMD_DB0_HI)) u_db0 (
        .addr (data_addr),
        .hit  (d_b0_w)
    );
    mmd_range #(.AW(MMD_AW), .LO(MMD_DB1_LO), .HI(MMD_DB1_HI)) u_db1 (
        .addr (data_addr),
        .hit  (d_b1_w)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Program space region, boot ROM takes priority over passwords
    mmd_preg_t preg;
    wire       boot_win = boot_rom_en && p_boot_w;
    wire       pwd_win  = !boot_win && p_pwd_w;
    wire       pb0_win  = block_zero_space_select && p_b0_w;
    assign preg = !prog_req ? MMD_P_NONE  :
                  boot_win  ? MMD_P_BOOT  :
                  pwd_win   ? MMD_P_PWD   :
                  pb0_win   ? MMD_P_B0    :
                  p_b0_w    ? MMD_P_NONE  :
                              MMD_P_FLASH;

    // Data space region; pages alias by dropping the page bits
    mmd_dreg_t dreg;
    wire       db0_win = !block_zero_space_select && d_b0_w;
    assign dreg = !data_req ? MMD_D_NONE :
                  db0_win   ? MMD_D_B0   :
                  d_b1_w    ? MMD_D_B1   :
                              MMD_D_NONE;

    // Low byte is the word inside every 256-word page, so mirrors share it
    wire [MMD_BLK_IDX_W-1:0] p_idx = prog_addr[MMD_BLK_IDX_W-1:0];
    wire [MMD_BLK_IDX_W-1:0] d_idx = data_addr[MMD_BLK_IDX_W-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Registered selects, one cycle after the address
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sel_boot_rom <= 1'b0;
            sel_pwd      <= 1'b0;
            sel_flash    <= 1'b0;
            prog_b0      <= '0;
            data_b0      <= '0;
            data_b1      <= '0;
        end else begin
            sel_boot_rom <= (preg == MMD_P_BOOT);
            sel_pwd      <= (preg == MMD_P_PWD);
            sel_flash    <= (preg == MMD_P_FLASH);
            prog_b0      <= '{hit: preg == MMD_P_B0, idx: p_idx};
            data_b0      <= '{hit: dreg == MMD_D_B0, idx: d_idx};
            data_b1      <= '{hit: dreg == MMD_D_B1, idx: d_idx};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // GPIO direction and output latch; inputs is the safe reset state
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            gpio_oe  <= {GPIO_N{MMD_GPIO_DIR_RST}};
            gpio_out <= {GPIO_N{MMD_GPIO_OUT_RST}};
        end else if (gpio_dir_we) begin
            gpio_oe  <= gpio_dir_wdata;
            gpio_out <= gpio_out_wdata;
        end
    end

    // Pin sampling, pins are taken as synchronous
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            gpio_rd <= '0;
        end else begin
            gpio_rd <= gpio_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_pb0_req;
        prog_req && block_zero_space_select && prog_addr >= MMD_PB0_LO;
    endsequence

    property p_boot;
        @(posedge sys_clk) disable iff (srst)
        prog_req && boot_rom_en && prog_addr <= MMD_BOOT_HI |=> sel_boot_rom && !sel_flash;
    endproperty
    a_boot: assert property (p_boot) else $error("boot ROM not selected");

    property p_pwd;
        @(posedge sys_clk) disable iff (srst)
        sel_flash |-> !($past(prog_addr) >= MMD_PWD_LO && $past(prog_addr) <= MMD_PWD_HI);
    endproperty
    a_pwd: assert property (p_pwd) else $error("password word used as code");

    property p_pb0;
        @(posedge sys_clk) disable iff (srst)
        s_pb0_req |=> prog_b0.hit && prog_b0.idx == $past(prog_addr[7:0]);
    endproperty
    a_pb0: assert property (p_pb0) else $error("program block zero alias wrong");

    property p_db0;
        @(posedge sys_clk) disable iff (srst)
        data_req && !block_zero_space_select && data_addr >= MMD_DB0_LO
            && data_addr <= MMD_DB0_HI |=> data_b0.hit && !data_b1.hit;
    endproperty
    a_db0: assert property (p_db0) else $error("data block zero alias wrong");

    property p_db1;
        @(posedge sys_clk) disable iff (srst)
        data_req && data_addr >= MMD_DB1_LO && data_addr <= MMD_DB1_HI
            |=> data_b1.hit && data_b1.idx == $past(data_addr[7:0]);
    endproperty
    a_db1: assert property (p_db1) else $error("block one alias wrong");

    property p_gpio;
        @(posedge sys_clk)
        srst |=> gpio_oe == '0 ##0 (!gpio_dir_we)[*1] |=> gpio_oe == '0;
    endproperty
    a_gpio: assert property (p_gpio) else $error("GPIO not input after reset");

    property p_excl;
        @(posedge sys_clk) disable iff (srst)
        !(prog_b0.hit && data_b0.hit);
    endproperty
    a_excl: assert property (p_excl) else $error("block zero in two spaces");

    property p_excl_cfg;
        @(posedge sys_clk) disable iff (srst)
        !block_zero_space_select |=> !prog_b0.hit;
    endproperty
    a_excl_cfg: assert property (p_excl_cfg) else $error("program hit in data mode");

    // Program side of block zero parked in data space: no flash either
    sequence s_pb0_blocked;
        prog_req && !block_zero_space_select && prog_addr >= MMD_PB0_LO;
    endsequence

    property p_pb0_off;
        @(posedge sys_clk) disable iff (srst)
        s_pb0_blocked |=> !prog_b0.hit && !sel_flash && !sel_boot_rom && !sel_pwd;
    endproperty
    a_pb0_off: assert property (p_pb0_off) else $error("program reached block zero");

    // Data side of block zero parked in program space: nothing answers
    sequence s_db0_blocked;
        data_req && block_zero_space_select && data_addr >= MMD_DB0_LO
            && data_addr <= MMD_DB0_HI;
    endsequence

    property p_db0_off;
        @(posedge sys_clk) disable iff (srst)
        s_db0_blocked |=> !data_b0.hit && !data_b1.hit;
    endproperty
    a_db0_off: assert property (p_db0_off) else $error("data reached block zero");

    // No request, no select
    property p_prog_idle;
        @(posedge sys_clk) disable iff (srst)
        !prog_req |=> !sel_boot_rom && !sel_pwd && !sel_flash && !prog_b0.hit;
    endproperty
    a_prog_idle: assert property (p_prog_idle) else $error("program select, no request");

    property p_data_idle;
        @(posedge sys_clk) disable iff (srst)
        !data_req |=> !data_b0.hit && !data_b1.hit;
    endproperty
    a_data_idle: assert property (p_data_idle) else $error("data hit, no request");

endmodule // mmd_top

// *** verilog/mmd_pkg.sv ***
/*
 * Package for the memory map address decoder: address ranges, region codes,
 * GPIO reset values and the registered decode result carrier.
 * Assumes 16-bit program and data address buses from the CPU core.
 */
package mmd_pkg;

    localparam int          MMD_AW              = 16;
    localparam int          MMD_GPIO_N          = 40;

    // Boot ROM window in program space
    localparam logic [15:0] MMD_BOOT_LO         = 16'h0000;
    localparam logic [15:0] MMD_BOOT_HI         = 16'h00FF;
    // Code security password words
    localparam logic [15:0] MMD_PWD_LO          = 16'h0040;
    localparam logic [15:0] MMD_PWD_HI          = 16'h0043;
    // Block zero in program space, two mirrored pages
    localparam logic [15:0] MMD_PB0_LO          = 16'hFE00;
    localparam logic [15:0] MMD_PB0_HI          = 16'hFFFF;
    // Block zero in data space, two mirrored pages
    localparam logic [15:0] MMD_DB0_LO          = 16'h0100;
    localparam logic [15:0] MMD_DB0_HI          = 16'h02FF;
    // Block one in data space, two mirrored pages
    localparam logic [15:0] MMD_DB1_LO          = 16'h0300;
    localparam logic [15:0] MMD_DB1_HI          = 16'h04FF;
    // Word index within a 256-word block
    localparam int          MMD_BLK_IDX_W       = 8;

    // Reset values
    localparam logic        MMD_GPIO_DIR_RST    = 1'b0;   // 0 = input
    localparam logic        MMD_GPIO_OUT_RST    = 1'b0;

    // Program space regions
    typedef enum logic [2:0] {
        MMD_P_NONE,
        MMD_P_BOOT,
        MMD_P_PWD,
        MMD_P_FLASH,
        MMD_P_B0
    } mmd_preg_t;

    // Data space regions
    typedef enum logic [1:0] {
        MMD_D_NONE,
        MMD_D_B0,
        MMD_D_B1
    } mmd_dreg_t;

    // Registered decode result for one bus
    typedef struct packed {
        logic                     hit;
        logic [MMD_BLK_IDX_W-1:0] idx;
    } mmd_sel_t;

endpackage

// *** verilog/mmd_range.sv ***
/*
 * Inclusive address range comparator, one per decoded window.
 * Assumes a single address bus of width AW; purely combinational.
 */
`timescale 1ns/10ps
module mmd_range #(
    parameter int          AW = 16,
    parameter logic [15:0] LO = 16'h0000,
    parameter logic [15:0] HI = 16'hFFFF
) (
    // Address in
    input  wire logic [AW-1:0] addr,
    // Inside window
    output wire logic          hit
);
    // Elaboration check; the window bounds are 16-bit constants
    if (AW != 16) begin : g_bad_aw
        $error("mmd_range serves 16-bit addresses only");
    end

    // Both bounds inclusive
    assign hit = (addr >= LO) && (addr <= HI);
endmodule // mmd_range

// *** tb/mmd_cpu_model.sv ***
/* CPU core model: drives the program and data address buses of mmd_top.
   Assumes its caller enters each task at a falling edge of sys_clk. */
`timescale 1ns/10ps
module mmd_cpu_model
    import mmd_pkg::*;
(
    // Clock
    input  wire logic              sys_clk,
    // Address buses toward the decoder
    output logic      [MMD_AW-1:0] prog_addr,
    output logic                   prog_req,
    output logic      [MMD_AW-1:0] data_addr,
    output logic                   data_req
);
    // Buses idle until the first access
    initial begin
        prog_addr = 16'h0000;
        prog_req  = 1'b0;
        data_addr = 16'h0000;
        data_req  = 1'b0;
    end

    // One access on both buses, held for one edge; back to back allowed
    task automatic cycle(input logic [15:0] pa, input logic pr,
                         input logic [15:0] da, input logic dr);
        prog_addr = pa;
        prog_req  = pr;
        data_addr = da;
        data_req  = dr;
        @(negedge sys_clk);
    endtask

    // Release: inverse of the last address so a stale value never passes
    task automatic idle;
        prog_req  = 1'b0;
        data_req  = 1'b0;
        prog_addr = ~prog_addr;
        data_addr = ~data_addr;
    endtask
endmodule // mmd_cpu_model

// *** tb/tb.sv ***
/* Self-checking bench for mmd_top: decode windows, aliasing, GPIO reset.
   Assumes latency one, inputs changed on the falling edge. */
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb;
    import mmd_pkg::*;
    localparam int GN = 8;
    int                fails     = 0;
    int                tests_run = 0;
    logic              sys_clk   = 1'b0;
    logic              srst      = 1'b1;
    logic              boot_rom_en = 1'b0;
    logic              block_zero_space_select = 1'b0;
    logic [MMD_AW-1:0] prog_addr, data_addr;
    logic              prog_req, data_req, sel_boot_rom, sel_pwd, sel_flash;
    mmd_sel_t          prog_b0, data_b0, data_b1;
    logic              gpio_dir_we = 1'b0;
    logic [GN-1:0]     gpio_dir_wdata = 8'h00, gpio_out_wdata = 8'h00, gpio_in = 8'h00;
    logic [GN-1:0]     gpio_out, gpio_oe, gpio_rd;

    always #20 sys_clk = ~sys_clk;

    mmd_cpu_model i_cpu (.sys_clk(sys_clk), .prog_addr(prog_addr), .prog_req(prog_req),
        .data_addr(data_addr), .data_req(data_req));
    mmd_top #(.GPIO_N(GN)) i_dut (.sys_clk(sys_clk), .srst(srst),
        .boot_rom_en(boot_rom_en), .block_zero_space_select(block_zero_space_select),
        .prog_addr(prog_addr), .prog_req(prog_req), .data_addr(data_addr),
        .data_req(data_req), .sel_boot_rom(sel_boot_rom), .sel_pwd(sel_pwd),
        .sel_flash(sel_flash), .prog_b0(prog_b0), .data_b0(data_b0), .data_b1(data_b1),
        .gpio_dir_we(gpio_dir_we), .gpio_dir_wdata(gpio_dir_wdata),
        .gpio_out_wdata(gpio_out_wdata), .gpio_in(gpio_in), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .gpio_rd(gpio_rd));

    ////////////////////////////////////////////////////////////////////////////
    // One access, expectation worked out here from the address map
    task automatic acc(input logic [15:0] pa, input logic pr,
                       input logic [15:0] da, input logic dr);
        logic bt, pw, pb, d0, d1;
        i_cpu.cycle(pa, pr, da, dr);
        bt = pr && boot_rom_en && pa <= 16'h00FF;
        pw = pr && !bt && pa >= 16'h0040 && pa <= 16'h0043;
        pb = pr && block_zero_space_select && pa >= 16'hFE00;
        d0 = dr && !block_zero_space_select && da >= 16'h0100 && da <= 16'h02FF;
        d1 = dr && da >= 16'h0300 && da <= 16'h04FF;
        `CHK(sel_boot_rom, bt)
        `CHK(sel_pwd, pw)
        `CHK(sel_flash, pr && !bt && !pw && pa < 16'hFE00)
        `CHK(prog_b0.hit, pb)
        `CHK(data_b0.hit, d0)
        `CHK(data_b1.hit, d1)
        if (pb) `CHK(prog_b0.idx, pa[7:0])
        if (d0) `CHK(data_b0.idx, da[7:0])
        if (d1) `CHK(data_b1.idx, da[7:0])
    endtask

    // Boot window and password words, boot ROM on and off
    task automatic t_boot;
        logic [15:0] al [6] = '{16'h0000, 16'h003F, 16'h0040, 16'h0043, 16'h00FF, 16'h0100};
        for (int e = 1; e >= 0; e--) begin
            boot_rom_en = e[0];
            foreach (al[i]) acc(al[i], 1'b1, 16'h0300, 1'b0);
        end
    endtask

    // Program mirrors of block zero for both select values; data bus on its mirror
    task automatic t_prog_b0;
        logic [15:0] al [5] = '{16'hFE00, 16'hFF00, 16'hFEFF, 16'hFF7A, 16'hFDFF};
        for (int s = 1; s >= 0; s--) begin
            block_zero_space_select = s[0];
            foreach (al[i]) acc(al[i], 1'b1, {8'h02, al[i][7:0]}, 1'b1);
        end
    endtask

    // Data mirrors of both blocks; program request low must hit nothing
    task automatic t_data;
        logic [15:0] al [8] = '{16'h00FF, 16'h0100, 16'h0200, 16'h02FF,
                                16'h0300, 16'h0400, 16'h04FF, 16'h0500};
        for (int s = 0; s <= 1; s++) begin
            block_zero_space_select = s[0];
            foreach (al[i]) acc(16'hFF00, 1'b0, al[i], 1'b1);
        end
        i_cpu.idle();
    endtask

    // Pins start as inputs, take a direction write, fall back on reset
    task automatic t_gpio;
        `CHK(gpio_oe, 8'h00)
        `CHK(gpio_out, 8'h00)
        gpio_dir_wdata = 8'hA5;
        gpio_out_wdata = 8'h3C;
        gpio_in = 8'h96;
        gpio_dir_we = 1'b1;
        @(negedge sys_clk);
        gpio_dir_we = 1'b0;
        `CHK({gpio_oe, gpio_out, gpio_rd}, 24'hA53C96)
        srst = 1'b1;
        i_cpu.cycle(16'h1000, 1'b1, 16'h0300, 1'b1);
        srst = 1'b0;
        `CHK(gpio_oe, 8'h00)
        `CHK(gpio_out, 8'h00)
        `CHK(gpio_rd, 8'h00)
        `CHK({sel_flash, data_b1.hit}, 2'b00)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic summarize;
        if (fails == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Guard against a hang
    initial begin
        #1000000;
        fails++;
        summarize();
    end

    // Main sequence
    initial begin
        repeat (6) @(negedge sys_clk);
        srst = 1'b0;
        t_gpio();
        t_boot();
        t_prog_b0();
        t_data();
        summarize();
    end
endmodule // tb
